// ---- rtl/alu_instruction_cycle_timing.sv ----
// Sequencer that spends the clocks and bus cycles of one ALU instruction
// form, and no fewer clocks than its bus cycles take. Assumes request inputs come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_params.svh"

module alu_instruction_cycle_timing
  import alu_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction request
  input wire logic start,
  input wire op_t op_sel,
  input wire size_t size_sel,
  input wire form_t form_sel,
  input wire logic loop_mode,
  input wire loop_case_t loop_case,
  input wire ea_mode_t ea_mode,
  // Operand address computation cost
  input wire logic [7:0] ea_clocks,
  input wire logic [3:0] ea_reads,
  input wire logic [1:0] ea_writes,
  input wire logic [2:0] imm_words,
  // Sequencer status
  output logic busy,
  output logic bus_read,
  output logic bus_write,
  output logic bus_cycle_start,
  output logic prefetch,
  output logic done,
  output logic reject,
  output logic [`TOTAL_W-1:0] total_clocks
);

  localparam logic [`SUB_W-1:0] BUS_LAST = `SUB_W'(`BUS_CYCLE_CLKS - 1);
  localparam logic [`TOTAL_W-1:0] BUS_CLKS = `TOTAL_W'(`BUS_CYCLE_CLKS);

  typedef struct packed {
    phase_t phase;
    logic [`READS_W-1:0] rd_left;
    logic [`TOTAL_W-1:0] int_left;
    logic [`WRITES_W-1:0] wr_left;
    logic [`SUB_W-1:0] sub;
    logic [7:0] ea_clk;
    logic [3:0] ea_rd;
    logic [1:0] ea_wr;
    logic [2:0] imm;
    logic predec_loop;
    logic bad_mode;
    logic busy;
    logic bus_rd;
    logic bus_wr;
    logic cyc_start;
    logic pf;
    logic done;
    logic reject;
    logic [`TOTAL_W-1:0] total;
  } state_t;

  state_t s_q;
  state_t s_d;
  timing_entry_t rom_q;
  logic rst_s1_q;
  logic rst_s2_q;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Base cost table
  alu_timing_rom u_rom (
    .clk(clk),
    .rst_n(rst_s2_q),
    .loop_mode(loop_mode),
    .loop_case(loop_case),
    .op_sel(op_sel),
    .size_sel(size_sel),
    .form_sel(form_sel),
    .entry_q(rom_q)
  );

  // First phase with work left; prefetch always closes
  function automatic phase_t first_phase(input logic rd, input logic it,
                                         input logic wr);
    if (rd) return PH_READ;
    else if (it) return PH_INT;
    else if (wr) return PH_WRITE;
    else return PH_PREFETCH;
  endfunction

  // Next state
  always_comb begin
    logic [`TOTAL_W-1:0] tot;
    logic [`TOTAL_W-1:0] bus_tot;
    logic [`READS_W-1:0] rds;
    logic [`WRITES_W-1:0] wrs;
    logic bad;
    tot = '0;
    bus_tot = '0;
    rds = '0;
    wrs = '0;
    bad = 1'b0;
    s_d = s_q;
    unique case (s_q.phase)
      PH_IDLE: begin
        if (start) begin
          s_d.phase = PH_LOOKUP;
          s_d.ea_clk = ea_clocks;
          s_d.ea_rd = ea_reads;
          s_d.ea_wr = ea_writes;
          s_d.imm = imm_words;
          s_d.predec_loop = loop_mode && (ea_mode == EA_PREDEC);
          s_d.bad_mode =
            (loop_mode && !(ea_mode == EA_IND || ea_mode == EA_POSTINC ||
                            ea_mode == EA_PREDEC)) ||
            (op_sel == OP_XOR && form_sel == F_TO_DREG &&
             ea_mode != EA_DREG) ||
            (form_sel == F_TO_AREG && size_sel == SZ_BYTE);
        end
      end
      PH_LOOKUP: begin
        // Base plus address computation, predecrement and immediates
        tot = `TOTAL_W'(rom_q.clocks)
            + (rom_q.add_ea ? `TOTAL_W'(s_q.ea_clk) : '0)
            + (s_q.predec_loop ? `TOTAL_W'(`PREDEC_LOOP_CLKS) : '0)
            + `TOTAL_W'(`TOTAL_W'(s_q.imm) * BUS_CLKS);
        rds = `READS_W'(rom_q.reads) + `READS_W'(s_q.imm)
            + (rom_q.add_ea ? `READS_W'(s_q.ea_rd) : '0);
        wrs = `WRITES_W'(rom_q.writes)
            + (rom_q.add_ea ? `WRITES_W'(s_q.ea_wr) : '0);
        bus_tot = `TOTAL_W'((`TOTAL_W'(rds) + `TOTAL_W'(wrs)) * BUS_CLKS);
        bad = !rom_q.valid || s_q.bad_mode || (rds == '0);
        if (bad) begin
          s_d.phase = PH_IDLE;
        end else begin
          // Last read is the prefetch; the rest run first
          s_d.rd_left = rds - `READS_W'(1);
          s_d.wr_left = wrs;
          s_d.int_left = (tot > bus_tot) ? tot - bus_tot : '0;
          s_d.total = bus_tot + s_d.int_left;
          s_d.sub = '0;
          s_d.phase = first_phase(s_d.rd_left != '0, s_d.int_left != '0,
                                  s_d.wr_left != '0);
        end
      end
      PH_READ: begin
        s_d.sub = s_q.sub + `SUB_W'(1);
        if (s_q.sub == BUS_LAST) begin
          s_d.sub = '0;
          s_d.rd_left = s_q.rd_left - `READS_W'(1);
          if (s_d.rd_left == '0)
            s_d.phase = first_phase(1'b0, s_q.int_left != '0,
                                    s_q.wr_left != '0);
        end
      end
      PH_INT: begin
        s_d.int_left = s_q.int_left - `TOTAL_W'(1);
        if (s_d.int_left == '0)
          s_d.phase = first_phase(1'b0, 1'b0, s_q.wr_left != '0);
      end
      PH_WRITE: begin
        s_d.sub = s_q.sub + `SUB_W'(1);
        if (s_q.sub == BUS_LAST) begin
          s_d.sub = '0;
          s_d.wr_left = s_q.wr_left - `WRITES_W'(1);
          if (s_d.wr_left == '0)
            s_d.phase = PH_PREFETCH;
        end
      end
      PH_PREFETCH: begin
        s_d.sub = s_q.sub + `SUB_W'(1);
        if (s_q.sub == BUS_LAST) begin
          s_d.sub = '0;
          s_d.phase = PH_IDLE;
        end
      end
      default: s_d.phase = PH_IDLE;
    endcase
    // Status derived from the coming phase; reject from the current lookup check
    s_d.busy = (s_d.phase == PH_READ) || (s_d.phase == PH_INT) ||
               (s_d.phase == PH_WRITE) || (s_d.phase == PH_PREFETCH);
    s_d.bus_rd = (s_d.phase == PH_READ) || (s_d.phase == PH_PREFETCH);
    s_d.bus_wr = (s_d.phase == PH_WRITE);
    s_d.cyc_start = (s_d.bus_rd || s_d.bus_wr) && (s_d.sub == '0);
    s_d.pf = (s_d.phase == PH_PREFETCH);
    s_d.done = s_d.pf && (s_d.sub == BUS_LAST);
    s_d.reject = (s_q.phase == PH_LOOKUP) && bad;
  end

  // State register
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign busy = s_q.busy;
  assign bus_read = s_q.bus_rd;
  assign bus_write = s_q.bus_wr;
  assign bus_cycle_start = s_q.cyc_start;
  assign prefetch = s_q.pf;
  assign done = s_q.done;
  assign reject = s_q.reject;
  assign total_clocks = s_q.total;

endmodule // alu_instruction_cycle_timing

`default_nettype wire

// ---- shared/alu_timing_params.svh ----
// Timing constants for the two-operand ALU instruction sequencer.
// Assumes a single processor clock domain.
`ifndef ALU_TIMING_PARAMS_SVH
`define ALU_TIMING_PARAMS_SVH

// Processor clock period
`define CLK_PERIOD_NS 10
// Least duration of one bus read or write cycle
`define BUS_CYCLE_NS 40
// Bus cycle length in clocks, rounded up
`define BUS_CYCLE_CLKS ((`BUS_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Extra clocks for predecrement operand in loop mode
`define PREDEC_LOOP_CLKS 2
// Widths of counters and reports
`define TOTAL_W 10
`define READS_W 5
`define WRITES_W 4
`define SUB_W 4

`endif

// ---- shared/alu_timing_pkg.sv ----
// Types for the ALU instruction cycle-timing sequencer.
// Assumes alu_timing_params.svh for widths.
`include "alu_timing_params.svh"

package alu_timing_pkg;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_AND = 4'h1, OP_CMP = 4'h2, OP_DIVS = 4'h3,
    OP_DIVU = 4'h4, OP_XOR = 4'h5, OP_MUL = 4'h6, OP_OR = 4'h7,
    OP_SUB = 4'h8
  } op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } size_t;

  // Destination form: ea to address reg, ea to data reg, data reg to memory
  typedef enum logic [1:0] {
    F_TO_AREG = 2'h0, F_TO_DREG = 2'h1, F_TO_MEM = 2'h2
  } form_t;

  typedef enum logic [1:0] {
    LC_CONTINUED = 2'h0, LC_CC_TRUE = 2'h1, LC_EXPIRED = 2'h2
  } loop_case_t;

  typedef enum logic [2:0] {
    EA_DREG = 3'h0, EA_AREG = 3'h1, EA_IND = 3'h2, EA_POSTINC = 3'h3,
    EA_PREDEC = 3'h4, EA_OTHER = 3'h5
  } ea_mode_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0, PH_LOOKUP = 3'h1, PH_READ = 3'h2, PH_INT = 3'h3,
    PH_WRITE = 3'h4, PH_PREFETCH = 3'h5
  } phase_t;

  typedef struct packed {
    logic valid;
    logic add_ea;
    logic [7:0] clocks;
    logic [2:0] reads;
    logic [1:0] writes;
  } timing_entry_t;

endpackage

// ---- rtl/alu_timing_rom.sv ----
// Registered lookup of base clock, read and write counts per form.
// Assumes selector inputs stable at the edge that starts a lookup.
`timescale 1ns/1ps
`default_nettype none

module alu_timing_rom
  import alu_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Selector
  input wire logic loop_mode,
  input wire loop_case_t loop_case,
  input wire op_t op_sel,
  input wire size_t size_sel,
  input wire form_t form_sel,
  // Registered entry
  output timing_entry_t entry_q
);

  // Pack one table entry
  function automatic timing_entry_t ent(input int c, input int r,
                                        input int w, input int ea);
    timing_entry_t e;
    e.valid = 1'b1;
    e.add_ea = (ea != 0);
    e.clocks = 8'(c);
    e.reads = 3'(r);
    e.writes = 2'(w);
    return e;
  endfunction

  // Pick one of three loop-case entries
  function automatic timing_entry_t sel3(input loop_case_t lc,
      input timing_entry_t a, input timing_entry_t b,
      input timing_entry_t c);
    timing_entry_t e;
    e = '0;
    unique case (lc)
      LC_CONTINUED: e = a;
      LC_CC_TRUE: e = b;
      LC_EXPIRED: e = c;
      default: e = '0;
    endcase
    return e;
  endfunction

  // Whole timing table
  function automatic timing_entry_t lookup(input logic lp,
      input loop_case_t lc, input op_t op, input size_t sz,
      input form_t f);
    timing_entry_t e;
    logic l;
    e = '0;
    l = (sz == SZ_LONG);
    if (!lp) begin
      unique case (op)
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_XOR: begin
          if (f == F_TO_AREG && (op == OP_ADD || op == OP_SUB))
            e = l ? ent(6, 1, 0, 1) : ent(8, 1, 0, 1);
          else if (f == F_TO_AREG && op == OP_CMP)
            e = ent(6, 1, 0, 1);
          else if (f == F_TO_DREG)
            e = l ? ent(6, 1, 0, int'(op != OP_XOR))
                  : ent(4, 1, 0, int'(op != OP_XOR));
          else if (f == F_TO_MEM && op != OP_CMP)
            e = l ? ent(12, 1, 2, 1) : ent(8, 1, 1, 1);
        end
        OP_DIVS: if (f == F_TO_DREG) e = ent(122, 1, 0, 1);
        OP_DIVU: if (f == F_TO_DREG) e = ent(108, 1, 0, 1);
        OP_MUL: if (f == F_TO_DREG) e = ent(42, 1, 0, 1);
        default: e = '0;
      endcase
    end else begin
      unique case (op)
        OP_ADD, OP_SUB: begin
          if (f == F_TO_AREG)
            e = l ? sel3(lc, ent(22, 2, 0, 0), ent(28, 4, 0, 0),
                         ent(26, 4, 0, 0))
                  : sel3(lc, ent(18, 1, 0, 0), ent(24, 3, 0, 0),
                         ent(22, 3, 0, 0));
          else if (f == F_TO_DREG && l && op == OP_SUB)
            e = sel3(lc, ent(20, 2, 0, 0), ent(26, 4, 0, 0),
                     ent(24, 4, 0, 0));
          else if (f == F_TO_DREG)
            e = l ? sel3(lc, ent(22, 2, 0, 0), ent(28, 4, 0, 0),
                         ent(26, 4, 0, 0))
                  : sel3(lc, ent(16, 1, 0, 0), ent(22, 3, 0, 0),
                         ent(20, 3, 0, 0));
          else if (f == F_TO_MEM)
            e = l ? sel3(lc, ent(24, 2, 2, 0), ent(30, 4, 2, 0),
                         ent(28, 4, 2, 0))
                  : sel3(lc, ent(16, 1, 1, 0), ent(22, 3, 1, 0),
                         ent(20, 3, 1, 0));
        end
        OP_AND, OP_OR, OP_XOR: begin
          if (f == F_TO_DREG && op != OP_XOR)
            e = l ? sel3(lc, ent(22, 2, 0, 0), ent(28, 4, 0, 0),
                         ent(26, 4, 0, 0))
                  : sel3(lc, ent(16, 1, 0, 0), ent(22, 3, 0, 0),
                         ent(20, 3, 0, 0));
          else if (f == F_TO_MEM)
            e = l ? sel3(lc, ent(24, 2, 2, 0), ent(30, 4, 2, 0),
                         ent(28, 4, 2, 0))
                  : sel3(lc, ent(16, 1, (op == OP_AND) ? 1 : 0, 0),
                         ent(22, 3, 1, 0), ent(20, 3, 1, 0));
        end
        OP_CMP: begin
          if (f == F_TO_AREG || f == F_TO_DREG)
            e = l ? sel3(lc, ent(18, 2, 0, 0), ent(24, 4, 0, 0),
                         ent(20, 4, 0, 0))
                  : sel3(lc, ent(12, 1, 0, 0), ent(18, 3, 0, 0),
                         (f == F_TO_DREG) ? ent(16, 4, 0, 0)
                                          : ent(16, 3, 0, 0));
        end
        default: e = '0;
      endcase
    end
    return e;
  endfunction

  // Entry registered one edge after the selector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_q <= '0;
    end else begin
      entry_q <= lookup(loop_mode, loop_case, op_sel, size_sel, form_sel);
    end
  end

endmodule // alu_timing_rom

`default_nettype wire

// ---- test/alu_timing_monitor.sv ----
// Checker of status and bus-cycle timing at the sequencer ports.
// Assumes one clock domain; bound to the sequencer top below.
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_params.svh"
module alu_timing_monitor
  import alu_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request
  input wire logic start,
  input wire size_t size_sel,
  input wire op_t op_sel,
  input wire form_t form_sel,
  input wire logic loop_mode,
  input wire ea_mode_t ea_mode,
  // Status
  input wire logic busy,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic bus_cycle_start,
  input wire logic prefetch,
  input wire logic done,
  input wire logic reject,
  input wire logic [`TOTAL_W-1:0] total_clocks
);
  logic [1:0] arm_q;
  logic [`TOTAL_W-1:0] run_q;
  logic go;
  // Edges since reset release and busy cycles so far
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 2'h0;
      run_q <= '0;
    end else begin
      arm_q <= (arm_q == 2'h3) ? arm_q : arm_q + 2'h1;
      run_q <= busy ? run_q + 1'b1 : '0;
    end
  end
  // Request that the sequencer must take
  assign go = start && !busy && arm_q[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_busy_rise; $rose(busy) |-> $past(start, 2); endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy rose without a request");
  property p_run_len; done |-> busy && run_q + 1'b1 == total_clocks;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("busy length differs from total");
  property p_done_end; done |=> !busy; endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy stayed after done");
  property p_total_hold; $changed(total_clocks) |-> $rose(busy); endproperty
  a_total_hold: assert property (p_total_hold)
    else $error("total changed outside a start");
  property p_bus_len;
    bus_cycle_start |-> (busy && (bus_read ^ bus_write)) [*4];
  endproperty
  a_bus_len: assert property (p_bus_len)
    else $error("bus cycle shorter than four clocks");
  property p_bus_gap; bus_cycle_start |=> !bus_cycle_start [*3]; endproperty
  a_bus_gap: assert property (p_bus_gap)
    else $error("bus cycle restarted early");
  property p_prefetch;
    $rose(prefetch) |-> (bus_read && !done) [*3] ##1 (done && prefetch);
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("prefetch not the final read");
  property p_idle_quiet; !busy |-> !(bus_read || bus_write || done);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("bus activity while idle");
  property p_loop_ea;
    go && loop_mode && !(ea_mode inside {EA_IND, EA_POSTINC, EA_PREDEC})
      |-> ##2 (reject && !busy);
  endproperty
  a_loop_ea: assert property (p_loop_ea)
    else $error("loop operand form not refused");
  property p_xor_src;
    go && op_sel == OP_XOR && form_sel == F_TO_DREG && ea_mode != EA_DREG
      |-> ##2 reject;
  endproperty
  a_xor_src: assert property (p_xor_src)
    else $error("xor memory source not refused");
  property p_areg_byte;
    go && form_sel == F_TO_AREG && size_sel == SZ_BYTE |-> ##2 reject;
  endproperty
  a_areg_byte: assert property (p_areg_byte)
    else $error("byte to address register not refused");
  // Main scenarios reached
  c_done: cover property (done && loop_mode);
  c_reject: cover property (reject);
  c_write: cover property (bus_cycle_start && bus_write);
endmodule // alu_timing_monitor
bind alu_instruction_cycle_timing alu_timing_monitor u_mon (.clk, .rst_b,
  .start, .size_sel, .op_sel, .form_sel, .loop_mode, .ea_mode, .busy,
  .bus_read, .bus_write, .bus_cycle_start, .prefetch, .done, .reject,
  .total_clocks);
`default_nettype wire

// ---- test/bus_memory_model.sv ----
// Memory on the processor bus: tallies the cycles it serves.
// Assumes bus status from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
  // Clock and bus status
  input wire logic clk,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic bus_cycle_start,
  // Cycle tallies
  output var int reads,
  output var int writes
);
  int rd_q = 0;
  int wr_q = 0;
  // Count each cycle as it opens
  always @(posedge clk) begin
    if (bus_cycle_start && bus_read) rd_q <= rd_q + 1;
    if (bus_cycle_start && bus_write) wr_q <= wr_q + 1;
  end
  // Tallies out
  assign reads = rd_q;
  assign writes = wr_q;
endmodule // bus_memory_model
`default_nettype wire

// ---- test/alu_instruction_cycle_timing_tb.sv ----
// Bench for the instruction timing sequencer with a memory model.
// Assumes the monitor is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_params.svh"
module alu_instruction_cycle_timing_tb
  import alu_timing_pkg::*;
;
  logic clk = 0, rst_b = 0, start = 0, loop_mode = 0;
  op_t op_sel = OP_ADD;
  size_t size_sel = SZ_WORD;
  form_t form_sel = F_TO_DREG;
  loop_case_t loop_case = LC_CONTINUED;
  ea_mode_t ea_mode = EA_DREG;
  logic [7:0] ea_clocks = '0;
  logic [3:0] ea_reads = '0;
  logic [1:0] ea_writes = '0;
  logic [2:0] imm_words = '0;
  logic busy, bus_read, bus_write, bus_cycle_start, prefetch, done, reject;
  logic [`TOTAL_W-1:0] total_clocks;
  int rd_cnt, wr_cnt, fails = 0, num_checks = 0;
  always #5 clk = ~clk;
  alu_instruction_cycle_timing dut (.clk, .rst_b, .start, .op_sel,
    .size_sel, .form_sel, .loop_mode, .loop_case, .ea_mode, .ea_clocks,
    .ea_reads, .ea_writes, .imm_words, .busy, .bus_read, .bus_write,
    .bus_cycle_start, .prefetch, .done, .reject, .total_clocks);
  bus_memory_model mem (.clk, .bus_read, .bus_write, .bus_cycle_start,
    .reads(rd_cnt), .writes(wr_cnt));
  // Count a comparison and report a mismatch
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // One request; et 0 means refusal, else clocks and bus cycles
  task automatic issue(input op_t op, input size_t sz, input form_t f,
    input logic lp, input loop_case_t lc, input ea_mode_t em,
    input logic [7:0] ec, input logic [3:0] er, input logic [1:0] ew,
    input logic [2:0] iw, input int et, input int xr, input int xw);
    int n, dn, r0, w0;
    logic pf;
    pf = 1'b0;
    op_sel = op;
    size_sel = sz;
    form_sel = f;
    loop_mode = lp;
    loop_case = lc;
    ea_mode = em;
    ea_clocks = ec;
    ea_reads = er;
    ea_writes = ew;
    imm_words = iw;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    r0 = rd_cnt;
    w0 = wr_cnt;
    n = 0;
    while (busy !== 1'b1 && reject !== 1'b1 && n < 8) begin
      @(posedge clk) #1;
      n++;
    end
    if (et == 0) chk(reject === 1'b1 && busy === 1'b0, "not refused");
    if (et == 0) return;
    n = 0;
    dn = 0;
    while (busy === 1'b1 && n < 300) begin
      if (done === 1'b1) begin
        dn = n + 1;
        pf = prefetch;
      end
      n++;
      @(posedge clk) #1;
    end
    chk(n == et && dn == et, "busy span or done place");
    chk(pf === 1'b1, "prefetch not at done");
    chk(total_clocks === `TOTAL_W'(et), "total clocks");
    chk(rd_cnt - r0 == xr && wr_cnt - w0 == xw, "bus cycle counts");
  endtask
  // Every operation, word into a data register
  task automatic t_ops;
    op_t ops[9] = '{OP_ADD, OP_AND, OP_CMP, OP_DIVS, OP_DIVU, OP_XOR,
      OP_MUL, OP_OR, OP_SUB};
    int clks[9] = '{4, 4, 4, 122, 108, 4, 42, 4, 4};
    for (int i = 0; i < 9; i++) begin
      issue(ops[i], SZ_WORD, F_TO_DREG, 0, LC_CONTINUED, EA_DREG, 0, 0, 0,
        0, clks[i], 1, 0);
    end
  endtask
  // Memory and address register destinations, byte refusal
  task automatic t_forms;
    issue(OP_ADD, SZ_WORD, F_TO_MEM, 0, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      8, 1, 1);
    issue(OP_SUB, SZ_LONG, F_TO_AREG, 0, LC_CONTINUED, EA_AREG, 0, 0, 0, 0,
      6, 1, 0);
    issue(OP_ADD, SZ_BYTE, F_TO_AREG, 0, LC_CONTINUED, EA_DREG, 0, 0, 0, 0,
      0, 0, 0);
    issue(OP_CMP, SZ_WORD, F_TO_MEM, 0, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      0, 0, 0);
    issue(OP_AND, SZ_LONG, F_TO_AREG, 0, LC_CONTINUED, EA_DREG, 0, 0, 0, 0,
      0, 0, 0);
  endtask
  // Address computation and immediate words add on
  task automatic t_extra;
    issue(OP_ADD, SZ_LONG, F_TO_MEM, 0, LC_CONTINUED, EA_OTHER, 4, 1, 0, 0,
      16, 2, 2);
    issue(OP_OR, SZ_WORD, F_TO_DREG, 0, LC_CONTINUED, EA_OTHER, 6, 1, 1, 0,
      12, 2, 1);
    issue(OP_ADD, SZ_WORD, F_TO_DREG, 0, LC_CONTINUED, EA_DREG, 0, 0, 0, 2,
      12, 3, 0);
  endtask
  // Xor into a data register ignores address cost, refuses memory
  task automatic t_xor;
    issue(OP_XOR, SZ_WORD, F_TO_DREG, 0, LC_CONTINUED, EA_DREG, 8, 1, 0, 0,
      4, 1, 0);
    issue(OP_XOR, SZ_WORD, F_TO_DREG, 0, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      0, 0, 0);
  endtask
  // Loop forms in each termination case
  task automatic t_loop;
    issue(OP_ADD, SZ_WORD, F_TO_MEM, 1, LC_CONTINUED, EA_IND, 8, 1, 0, 0,
      16, 1, 1);
    issue(OP_ADD, SZ_WORD, F_TO_MEM, 1, LC_CONTINUED, EA_PREDEC, 0, 0, 0, 0,
      18, 1, 1);
    issue(OP_ADD, SZ_WORD, F_TO_DREG, 1, LC_CC_TRUE, EA_POSTINC, 0, 0, 0, 0,
      22, 3, 0);
    issue(OP_SUB, SZ_LONG, F_TO_DREG, 1, LC_EXPIRED, EA_IND, 0, 0, 0, 0,
      24, 4, 0);
    issue(OP_ADD, SZ_WORD, F_TO_AREG, 1, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      18, 1, 0);
    issue(OP_CMP, SZ_WORD, F_TO_DREG, 1, LC_EXPIRED, EA_POSTINC, 0, 0, 0, 0,
      16, 4, 0);
    issue(OP_OR, SZ_WORD, F_TO_MEM, 1, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      16, 1, 0);
    issue(OP_AND, SZ_LONG, F_TO_MEM, 1, LC_CC_TRUE, EA_PREDEC, 0, 0, 0, 0,
      32, 4, 2);
    issue(OP_DIVS, SZ_WORD, F_TO_DREG, 1, LC_CONTINUED, EA_IND, 0, 0, 0, 0,
      0, 0, 0);
    issue(OP_ADD, SZ_WORD, F_TO_DREG, 1, LC_CONTINUED, EA_OTHER, 0, 0, 0, 0,
      0, 0, 0);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  // Reset, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    repeat (3) @(posedge clk) #1;
    t_ops();
    t_forms();
    t_extra();
    t_xor();
    t_loop();
    stop_test();
  end
endmodule // alu_instruction_cycle_timing_tb
`default_nettype wire
